// ### rtl/dsr_pkg.sv
// Function
// R1 - enable bit gates activation; hardware commands still allowed when clear
// R2 - enable sets after special single-chip reset; withheld until erase-verify when secured
// R3 - host sees enable as one in special mode unless secured and not erased
// R4 - active flag set by hardware on entry, cleared only by firmware exit
// R5 - active flag maps the standard firmware table
// R6 - firmware exit store clears active flag and unmaps debug memory
// R7 - shift-data-valid sets after read data sent or write data received
// R8 - shift-data-valid clears on next command or debug exit
// R9 - single-step flag sets on step command, holds until resume
// R10 - security-off writable only in special mode by secure firmware when secured
// R11 - security-off zero on secure entry maps secure table over standard
// R12 - erased flash sets security-off and unmaps secure table; failure keeps zero
// R13 - host reads security-off one only when secured and erased in special mode; code also reads one after a firmware write of one that R10 allows
// R14 - security-off lifts security until next reset
// R15 - register accessible only via debug operations while not secured
// R16 - host sets enable by hardware command only when firmware commands needed
// R17 - other parties leave valid, step and security-off bits to hardware and firmware
// R18 - host enables debug by byte-write of the status register
// R19 - enter-debug command ignored while enable clear, processor not delayed
// R20 - bits 5, 2, 0 read zero; reset zero except active flag in special mode
package dsr_pkg;
    localparam logic [17:0] DEBUG_STATUS_ADDR = 18'h3ff01;
    localparam int EN_POS = 7;
    localparam int ACT_POS = 6;
    localparam int SDV_POS = 4;
    localparam int STEP_POS = 3;
    localparam int SOFF_POS = 1;
    localparam logic [7:0] IMPL_MASK = 8'hda;
    localparam logic [7:0] RESET_NORMAL = 8'h00;
    localparam logic [7:0] RESET_SPECIAL = 8'h40;
    localparam logic [7:0] FAMILY_ID = 8'h5a; // arbitrary value
    typedef enum logic [2:0] {
        SEC_IDLE = 3'b001,
        SEC_VERIFY = 3'b010,
        SEC_DONE = 3'b100
    } dsr_sec_type;
endpackage

// ### rtl/dsr_sec_seq.sv
`timescale 1ns/1ns
// tracks the erase-verify phase after a special-mode reset
module dsr_sec_seq (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic special_mode,
    input wire logic secured,
    input wire logic verify_done,
    input wire logic verify_erased,
    output logic set_enable,
    output logic set_soff,
    output logic secure_table_on
);
    import dsr_pkg::*;
    dsr_sec_type state_q;
    logic started_q;

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            started_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= SEC_IDLE;
        end else begin
            case (state_q)
                SEC_IDLE: begin
                    if (!started_q && special_mode && secured) begin
                        state_q <= SEC_VERIFY; // see R11
                    end else if (!started_q) begin
                        state_q <= SEC_DONE;
                    end
                end
                SEC_VERIFY: begin
                    if (verify_done) begin
                        state_q <= SEC_DONE; // see R2
                    end
                end
                SEC_DONE: state_q <= SEC_DONE;
                default: state_q <= SEC_IDLE;
            endcase
        end
    end

    // one pulse: end of the check, or straight after a special-mode release when unsecured
    assign set_enable = special_mode && ((state_q == SEC_IDLE && !started_q && !secured)
        || (state_q == SEC_VERIFY && verify_done)); // see R2
    assign set_soff = state_q == SEC_VERIFY && verify_done && verify_erased; // see R12
    assign secure_table_on = state_q != SEC_DONE; // see R11
endmodule

// ### rtl/dsr_top.sv
`timescale 1ns/1ns
module dsr_top (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic SPECIAL_MODE,
    input wire logic SECURED,
    input wire logic VERIFY_DONE,
    input wire logic VERIFY_ERASED,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic REG_FW,
    input wire logic REG_SECFW,
    input wire logic [17:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic REG_HIT,
    input wire logic ENTER_REQ,
    input wire logic FW_EXIT_STORE,
    input wire logic DATA_SENT,
    input wire logic DATA_RECEIVED,
    input wire logic CMD_RECEIVED,
    input wire logic STEP_CMD,
    input wire logic RESUME_CMD,
    output logic ENTER_ACCEPT,
    output logic STD_TABLE_MAPPED,
    output logic SEC_TABLE_MAPPED,
    output logic SECURITY_LIFTED,
    output logic DEBUG_ENABLED
);
    import dsr_pkg::*;
    logic en_q, act_q, sdv_q, step_q, soff_q;
    logic set_en, set_soff, sec_on, init_q;
    logic hit, wr_ok, soff_wr_ok;

    dsr_sec_seq u_seq (
        .CLK_SYS(CLK_SYS),
        .ARST_N(ARST_N),
        .special_mode(SPECIAL_MODE),
        .secured(SECURED),
        .verify_done(VERIFY_DONE),
        .verify_erased(VERIFY_ERASED),
        .set_enable(set_en),
        .set_soff(set_soff),
        .secure_table_on(sec_on)
    );

    assign hit = REG_ADDR == DEBUG_STATUS_ADDR;
    // secured part: register reads and writes need security-off set, except a secure firmware write of security-off in special mode
    assign wr_ok = REG_WR && hit && (!SECURED || soff_q); // see R15
    assign soff_wr_ok = REG_WR && hit && (!SECURED || (SPECIAL_MODE && REG_SECFW)); // see R10
    assign REG_HIT = hit && (REG_RD || REG_WR);

    // reset mode is a strap level, caught on the first edge after release
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            init_q <= 1'b0;
        end else begin
            init_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            en_q <= RESET_NORMAL[EN_POS];
        end else if (set_en) begin
            en_q <= 1'b1; // see R2 see R3
        end else if (wr_ok) begin
            en_q <= REG_WDATA[EN_POS]; // see R18
        end
    end

    // entry wins over a firmware store in the same cycle
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            act_q <= RESET_NORMAL[ACT_POS];
        end else if (!init_q) begin
            act_q <= SPECIAL_MODE ? RESET_SPECIAL[ACT_POS] : RESET_NORMAL[ACT_POS]; // see R20
        end else if (ENTER_ACCEPT) begin
            act_q <= 1'b1; // see R4
        end else if (FW_EXIT_STORE) begin
            act_q <= 1'b0; // see R4 see R6
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            sdv_q <= 1'b0;
        end else if (DATA_SENT || DATA_RECEIVED) begin
            sdv_q <= 1'b1; // see R7
        end else if (CMD_RECEIVED || FW_EXIT_STORE) begin
            sdv_q <= 1'b0; // see R8
        end else if (wr_ok && REG_FW) begin
            sdv_q <= REG_WDATA[SDV_POS];
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            step_q <= 1'b0;
        end else if (STEP_CMD) begin
            step_q <= 1'b1; // see R9
        end else if (RESUME_CMD) begin
            step_q <= 1'b0; // see R9
        end else if (wr_ok && REG_FW) begin
            step_q <= REG_WDATA[STEP_POS];
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            soff_q <= 1'b0; // see R11
        end else if (set_soff) begin
            soff_q <= 1'b1; // see R12
        end else if (soff_wr_ok && (REG_FW || REG_SECFW)) begin
            soff_q <= REG_WDATA[SOFF_POS]; // see R10
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD && hit && (!SECURED || soff_q)) begin
            REG_RDATA <= {en_q, act_q, 1'b0, sdv_q, step_q, 1'b0, soff_q, 1'b0}
                & IMPL_MASK; // see R13 see R15 see R20
        end else if (REG_RD) begin
            REG_RDATA <= 8'h00;
        end
    end

    assign ENTER_ACCEPT = ENTER_REQ && en_q && !act_q; // see R1 see R19
    assign STD_TABLE_MAPPED = act_q && !(sec_on && SPECIAL_MODE && SECURED); // see R5
    // a failed erase check leaves security-off low, so the secure table stays in
    assign SEC_TABLE_MAPPED = SPECIAL_MODE && SECURED && !soff_q; // see R11 see R12
    assign SECURITY_LIFTED = soff_q; // see R14
    assign DEBUG_ENABLED = en_q; // see R1

    a_enter_gated: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        ENTER_REQ && !en_q |-> !ENTER_ACCEPT) else $error("entry while disabled"); // see R19
    a_act_set: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        init_q && ENTER_ACCEPT |=> act_q) else $error("active not set"); // see R4
    a_act_clear: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        init_q && act_q && !FW_EXIT_STORE |=> act_q) else $error("active lost"); // see R6
    a_sdv_set: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        DATA_SENT || DATA_RECEIVED |=> sdv_q) else $error("valid not set"); // see R7
    a_sdv_clear: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        CMD_RECEIVED && !DATA_SENT && !DATA_RECEIVED |=> !sdv_q)
        else $error("valid not cleared"); // see R8
    a_step_hold: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        step_q && !RESUME_CMD && !wr_ok |=> step_q) else $error("step dropped"); // see R9
    a_soff_erased: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        set_soff |=> soff_q && !SEC_TABLE_MAPPED) else $error("unsecure failed"); // see R12
    a_soff_locked: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        SECURED && !SPECIAL_MODE && !set_soff |=> soff_q == $past(soff_q))
        else $error("soff changed"); // see R10
    a_read_zero: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
        REG_RDATA[5] == 1'b0 && REG_RDATA[2] == 1'b0 && REG_RDATA[0] == 1'b0)
        else $error("reserved bit set"); // see R20
endmodule

// ### tb/dsr_host_model.sv
`timescale 1ns/1ns
// host pod side: single byte accesses over the debug link
module dsr_host_model (
    input wire logic clk,
    output logic wr,
    output logic rd,
    output logic fw,
    output logic secfw,
    output logic [17:0] addr,
    output logic [7:0] wdata,
    output logic ack
);
    initial begin
        {wr, rd, fw, secfw, ack, addr, wdata} = '0;
    end
    // firmware stores share this path, flagged by f; plain host accesses keep it low
    // released address and data lines show inverted values so stale data cannot pass for fresh
    task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d,
                        input logic s, input logic f = 1'b0);
        @(negedge clk);
        {wr, rd, fw, secfw, addr, wdata} = {w, !w, f, s, a, d};
        @(negedge clk);
        {wr, rd, fw, secfw, addr, wdata} = {4'b0000, ~a, ~d};
        @(negedge clk);
        ack = !w;
        @(negedge clk);
        ack = 0;
    endtask
endmodule

// ### tb/dsr_top_tb_top.sv
`timescale 1ns/1ns
module dsr_top_tb_top;
    import dsr_pkg::*;
    logic clk_sys, arst_n, special, secured, erased, wr, rd, fw, secfw, ack, hit;
    logic accept, std_map, sec_map, lifted, enabled;
    logic [7:0] ev, wdata, rdata;
    logic [17:0] addr, a;
    logic [7:0] exp_q[$];
    int n_errors = 0;
    int compares = 0;
    int seq_k[8] = '{2, 4, 3, 5, 4, 6, 2, 1};
    logic [7:0] seq_e[8] = '{8'hd0, 8'hc0, 8'hd0, 8'hd8, 8'hc8, 8'hc0, 8'hd0, 8'h80};
    dsr_top i_dsr_top (.CLK_SYS(clk_sys), .ARST_N(arst_n), .SPECIAL_MODE(special),
        .SECURED(secured), .VERIFY_DONE(ev[7]), .VERIFY_ERASED(erased), .REG_WR(wr),
        .REG_RD(rd), .REG_FW(fw), .REG_SECFW(secfw), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .REG_HIT(hit), .ENTER_REQ(ev[0]), .FW_EXIT_STORE(ev[1]),
        .DATA_SENT(ev[2]), .DATA_RECEIVED(ev[3]), .CMD_RECEIVED(ev[4]), .STEP_CMD(ev[5]),
        .RESUME_CMD(ev[6]), .ENTER_ACCEPT(accept), .STD_TABLE_MAPPED(std_map),
        .SEC_TABLE_MAPPED(sec_map), .SECURITY_LIFTED(lifted), .DEBUG_ENABLED(enabled));
    dsr_host_model i_dsr_host_model (.clk(clk_sys), .wr(wr), .rd(rd), .fw(fw),
        .secfw(secfw), .addr(addr), .wdata(wdata), .ack(ack));
    task automatic check8(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic check1(input string n, input logic e, input logic s);
        check8(n, {7'h00, e}, {7'h00, s});
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic boot(input logic sp, input logic sc);
        @(negedge clk_sys);
        {arst_n, special, secured} = {1'b0, sp, sc};
        repeat (3) @(negedge clk_sys);
        arst_n = 1;
        repeat (2) @(negedge clk_sys);
    endtask
    // an enter request is judged while it is still raised
    task automatic pulse(input int k, input logic e);
        @(negedge clk_sys);
        ev[k] = 1;
        #2;
        if (k == 0) check1("accept", e, accept);
        @(negedge clk_sys);
        ev = '0;
    endtask
    task automatic wrx(input logic [7:0] d, input logic [17:0] ad = DEBUG_STATUS_ADDR,
                       input logic s = 0, input logic f = 0);
        i_dsr_host_model.xfer(1, ad, d, s, f);
    endtask
    task automatic rdx(input logic [7:0] e, input logic [17:0] ad = DEBUG_STATUS_ADDR);
        exp_q.push_back(e);
        i_dsr_host_model.xfer(0, ad, 8'h00, 0);
    endtask
    always @(posedge clk_sys) begin
        if (rd || wr) check1("hit", addr == DEBUG_STATUS_ADDR, hit);
        if (ack && exp_q.size() > 0) check8("status", exp_q.pop_front(), rdata);
    end
    initial begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        #40000;
        n_errors++;
        stop_test;
    end
    initial begin
        {arst_n, special, secured, erased, ev} = '0;
        void'($urandom(74254));
        boot(0, 0);
        rdx(8'h00);
        pulse(0, 0);
        wrx(8'h80);
        rdx(8'h80);
        pulse(0, 1);
        check1("std_map", 1, std_map);
        wrx(8'ha5);
        rdx(8'hc0);
        pulse(0, 0);
        for (int i = 0; i < 8; i++) begin
            pulse(seq_k[i], 0);
            rdx(seq_e[i]);
        end
        check1("std_map", 0, std_map);
        repeat (4) begin
            a = DEBUG_STATUS_ADDR ^ 18'($urandom_range(1, 255));
            wrx(8'($urandom()), a);
            rdx(8'h00, a);
        end
        rdx(8'h80);
        wrx(8'h9a, DEBUG_STATUS_ADDR, 0, 1);
        rdx(8'h9a);
        wrx(8'h00, DEBUG_STATUS_ADDR, 0, 1);
        rdx(8'h00);
        pulse(0, 0);
        $display("test normal done");
        boot(1, 0);
        rdx(8'hc0);
        check1("std_map", 1, std_map);
        boot(1, 1);
        check1("sec_map", 1, sec_map);
        check1("enabled", 0, enabled);
        rdx(8'h00);
        erased = 1;
        pulse(7, 0);
        check1("sec_map", 0, sec_map);
        check1("lifted", 1, lifted);
        rdx(8'hc2);
        $display("test erased done");
        erased = 0;
        boot(1, 1);
        pulse(7, 0);
        check1("enabled", 1, enabled);
        check1("sec_map", 1, sec_map);
        rdx(8'h00);
        wrx(8'h02);
        check1("lifted", 0, lifted);
        wrx(8'h02, DEBUG_STATUS_ADDR, 1);
        rdx(8'hc2);
        check1("sec_map", 0, sec_map);
        boot(0, 1);
        check1("lifted", 0, lifted);
        wrx(8'h80);
        rdx(8'h00);
        check1("enabled", 0, enabled);
        $display("test secured done");
        repeat (4) @(negedge clk_sys);
        stop_test;
    end
endmodule
